/* File: src/pdj_top.sv */
`timescale 1ns/1ps
module pdj_top
   import pdj_pkg::*;
#(
   parameter int WIN_W = 8
) (
   input  wire logic                   clk_sys,
   input  wire logic                   sys_rst,
   input  wire pdj_req_t               reg_req,
   output logic [7:0]                  rd_data_ff,
   output logic                        rd_valid_ff,
   input  wire logic                   mem_req,
   output logic                        mem_grant_ff,
   output logic                        mem_reject_ff,
   input  wire logic [PDJ_DJ_NUM-1:0]  frame_in,
   output logic [PDJ_DJ_NUM-1:0]       sample_stb_ff,
   output logic [PDJ_DJ_NUM-1:0]       dejit_stuck_ff,
   output logic [3:0]                  pad_pull_up_ff,
   output logic [3:0]                  pad_pull_down_ff,
   output logic [3:0]                  pad_drive_hi_ff,
   output logic                        cko_drive_hi_ff,
   output logic                        cko_pull_up_ff,
   output logic                        cko_pull_down_ff,
   output logic [7:0]                  dejit_window_ff,
   output pdj_gate_t                   gate_ff
);

   initial begin
      if (WIN_W != 8) begin
         $error("pdj_top: dejitter window register is eight bits wide");
      end
   end

   // -----------------------------------------------------------------
   // Register storage
   // -----------------------------------------------------------------
   logic [7:0] comm_pad_pulls_ff;
   logic [7:0] comm_pad_drive_ff;
   logic [7:0] clock_out_pad_control_ff;
   logic [7:0] digital_power_gate_0_ff;

   function automatic logic [7:0] merge(input logic [7:0] wdata, input logic [7:0] msk);
      merge = wdata & msk;
   endfunction

   function automatic logic hit(input pdj_req_t req, input logic [15:0] off);
      hit = req.wr && (req.addr == off);
   endfunction

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         comm_pad_pulls_ff <= PDJ_RST_COMM_PULLS;
      end else if (hit(reg_req, PDJ_OFF_COMM_PULLS)) begin
         comm_pad_pulls_ff <= merge(reg_req.wdata, PDJ_MSK_COMM_PULLS);
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         comm_pad_drive_ff <= PDJ_RST_COMM_DRIVE;
      end else if (hit(reg_req, PDJ_OFF_COMM_DRIVE)) begin
         comm_pad_drive_ff <= merge(reg_req.wdata, PDJ_MSK_COMM_DRIVE);
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         clock_out_pad_control_ff <= PDJ_RST_CLKOUT_PAD;
      end else if (hit(reg_req, PDJ_OFF_CLKOUT_PAD)) begin
         clock_out_pad_control_ff <= merge(reg_req.wdata, PDJ_MSK_CLKOUT_PAD);
      end
   end

   // Window feeds all four circuits straight from this flop
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         dejit_window_ff <= PDJ_RST_DEJIT_WIN;
      end else if (hit(reg_req, PDJ_OFF_DEJIT_WIN)) begin
         dejit_window_ff <= merge(reg_req.wdata, PDJ_MSK_DEJIT_WIN);
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         digital_power_gate_0_ff <= PDJ_RST_PWR_GATE0;
      end else if (hit(reg_req, PDJ_OFF_PWR_GATE0)) begin
         digital_power_gate_0_ff <= merge(reg_req.wdata, PDJ_MSK_PWR_GATE0);
      end
   end

   // -----------------------------------------------------------------
   // Read-back, one cycle after the read strobe
   // -----------------------------------------------------------------
   logic [7:0] rd_mux;

   always_comb begin
      unique case (reg_req.addr)
         PDJ_OFF_COMM_PULLS: rd_mux = comm_pad_pulls_ff;
         PDJ_OFF_COMM_DRIVE: rd_mux = comm_pad_drive_ff;
         PDJ_OFF_CLKOUT_PAD: rd_mux = clock_out_pad_control_ff;
         PDJ_OFF_DEJIT_WIN:  rd_mux = dejit_window_ff;
         PDJ_OFF_PWR_GATE0:  rd_mux = digital_power_gate_0_ff;
         default:            rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rd_data_ff  <= 8'h00;
         rd_valid_ff <= 1'b0;
      end else begin
         rd_valid_ff <= reg_req.rd;
         rd_data_ff  <= reg_req.rd ? rd_mux : 8'h00;
      end
   end

   // -----------------------------------------------------------------
   // Pad controls
   // -----------------------------------------------------------------
   function automatic logic [1:0] pull_sel(input logic [7:0] r, input int lsb);
      pull_sel = r[lsb +: 2];
   endfunction

   logic [1:0] sel_q [4];

   always_comb begin
      sel_q[3] = pull_sel(comm_pad_pulls_ff, PDJ_PULL_DATA_IN_LSB);
      sel_q[2] = pull_sel(comm_pad_pulls_ff, PDJ_PULL_LATCH_LSB);
      sel_q[1] = pull_sel(comm_pad_pulls_ff, PDJ_PULL_CLOCK_LSB);
      sel_q[0] = pull_sel(comm_pad_pulls_ff, PDJ_PULL_DATA_OUT_LSB);
   end

   // Reserved code 01 drives neither device, same as no pull
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pad_pull_up_ff   <= 4'h0;
         pad_pull_down_ff <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            pad_pull_up_ff[i]   <= (sel_q[i] == PDJ_PULL_UP);
            pad_pull_down_ff[i] <= (sel_q[i] == PDJ_PULL_DOWN);
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pad_drive_hi_ff  <= 4'h0;
         cko_drive_hi_ff  <= 1'b0;
         cko_pull_up_ff   <= 1'b0;
         cko_pull_down_ff <= 1'b0;
      end else begin
         pad_drive_hi_ff  <= comm_pad_drive_ff[3:0];
         cko_drive_hi_ff  <= clock_out_pad_control_ff[PDJ_CKO_DRIVE_BIT];
         // Taken as active low: zero turns the pull-up on
         cko_pull_up_ff   <= !clock_out_pad_control_ff[PDJ_CKO_PU_N_BIT];
         cko_pull_down_ff <= clock_out_pad_control_ff[PDJ_CKO_PD_BIT];
      end
   end

   // -----------------------------------------------------------------
   // Subsystem gating
   // -----------------------------------------------------------------
   logic pg_adc, pg_mem, pg_xfer, pg_sport, pg_rec, pg_play, pg_clk, pg_core;

   assign pg_adc   = digital_power_gate_0_ff[PDJ_PG_ADC_BIT];
   assign pg_mem   = digital_power_gate_0_ff[PDJ_PG_MEM_BIT];
   assign pg_xfer  = digital_power_gate_0_ff[PDJ_PG_XFER_BIT];
   assign pg_sport = digital_power_gate_0_ff[PDJ_PG_SPORT_BIT];
   assign pg_rec   = digital_power_gate_0_ff[PDJ_PG_REC_BIT];
   assign pg_play  = digital_power_gate_0_ff[PDJ_PG_PLAY_BIT];
   assign pg_clk   = digital_power_gate_0_ff[PDJ_PG_CLKGEN_BIT];
   assign pg_core  = digital_power_gate_0_ff[PDJ_PG_CORE_BIT];

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         gate_ff <= '0;
      end else begin
         gate_ff.adc_en        <= pg_adc && pg_mem;
         gate_ff.dmic_en       <= pg_adc;
         gate_ff.mem_en        <= pg_mem && pg_core;
         gate_ff.sport_en      <= pg_xfer || pg_sport;
         gate_ff.rec_route_en  <= pg_rec;
         gate_ff.play_route_en <= pg_play;
         gate_ff.clkgen_en     <= pg_clk;
         gate_ff.core_en       <= pg_core && pg_mem;
         gate_ff.dac_en        <= pg_mem;
      end
   end

   // -----------------------------------------------------------------
   // Control-port memory access arbitration
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         mem_grant_ff  <= 1'b0;
         mem_reject_ff <= 1'b0;
      end else begin
         mem_grant_ff  <= mem_req && pg_mem && pg_core;
         mem_reject_ff <= mem_req && !(pg_mem && pg_core);
      end
   end

   // -----------------------------------------------------------------
   // Dejitter circuits, one each for ADC, SPORT, CORE and DAC
   // -----------------------------------------------------------------
   // No audio moves without the clock generator, so it gates every circuit
   logic [PDJ_DJ_NUM-1:0] dj_en;

   assign dj_en[PDJ_DJ_ADC]   = pg_adc && pg_mem && pg_clk;
   assign dj_en[PDJ_DJ_SPORT] = (pg_xfer || pg_sport) && pg_clk;
   assign dj_en[PDJ_DJ_CORE]  = pg_core && pg_mem && pg_clk;
   assign dj_en[PDJ_DJ_DAC]   = pg_mem && pg_clk;

   for (genvar g = 0; g < PDJ_DJ_NUM; g++) begin : g_dj
      pdj_dejitter #(
         .WIN_W (WIN_W)
      ) u_dj (
         .clk_sys       (clk_sys),
         .sys_rst       (sys_rst),
         .window        (dejit_window_ff),
         .subsys_en     (dj_en[g]),
         .frame_async   (frame_in[g]),
         .sample_stb_ff (sample_stb_ff[g]),
         .stuck_ff      (dejit_stuck_ff[g])
      );
   end

endmodule

/* File: pkg/pdj_pkg.sv */
package pdj_pkg;

   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [15:0] PDJ_OFF_COMM_PULLS  = 16'h402F;
   localparam logic [15:0] PDJ_OFF_COMM_DRIVE  = 16'h4030;
   localparam logic [15:0] PDJ_OFF_CLKOUT_PAD  = 16'h4031;
   localparam logic [15:0] PDJ_OFF_DEJIT_WIN   = 16'h4032;
   localparam logic [15:0] PDJ_OFF_PWR_GATE0   = 16'h4080;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] PDJ_RST_COMM_PULLS   = 8'hCF;
   localparam logic [7:0] PDJ_RST_COMM_DRIVE   = 8'h00;
   localparam logic [7:0] PDJ_RST_CLKOUT_PAD   = 8'h01;
   localparam logic [7:0] PDJ_RST_DEJIT_WIN    = 8'h05;
   localparam logic [7:0] PDJ_RST_PWR_GATE0    = 8'h00;

   // -----------------------------------------------------------------
   // Writable bit masks (reserved bits stay zero)
   // -----------------------------------------------------------------
   localparam logic [7:0] PDJ_MSK_COMM_PULLS   = 8'hFF;
   localparam logic [7:0] PDJ_MSK_COMM_DRIVE   = 8'h0F;
   localparam logic [7:0] PDJ_MSK_CLKOUT_PAD   = 8'h07;
   localparam logic [7:0] PDJ_MSK_DEJIT_WIN    = 8'hFF;
   localparam logic [7:0] PDJ_MSK_PWR_GATE0    = 8'hFF;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int PDJ_PULL_DATA_IN_LSB  = 6;
   localparam int PDJ_PULL_LATCH_LSB    = 4;
   localparam int PDJ_PULL_CLOCK_LSB    = 2;
   localparam int PDJ_PULL_DATA_OUT_LSB = 0;
   localparam int PDJ_CKO_DRIVE_BIT     = 2;
   localparam int PDJ_CKO_PU_N_BIT      = 1;
   localparam int PDJ_CKO_PD_BIT        = 0;
   localparam int PDJ_PG_ADC_BIT        = 7;
   localparam int PDJ_PG_MEM_BIT        = 6;
   localparam int PDJ_PG_XFER_BIT       = 5;
   localparam int PDJ_PG_SPORT_BIT      = 4;
   localparam int PDJ_PG_REC_BIT        = 3;
   localparam int PDJ_PG_PLAY_BIT       = 2;
   localparam int PDJ_PG_CLKGEN_BIT     = 1;
   localparam int PDJ_PG_CORE_BIT       = 0;

   // -----------------------------------------------------------------
   // Pull selector codes
   // -----------------------------------------------------------------
   localparam logic [1:0] PDJ_PULL_UP   = 2'h0;
   localparam logic [1:0] PDJ_PULL_RSVD = 2'h1;
   localparam logic [1:0] PDJ_PULL_NONE = 2'h2;
   localparam logic [1:0] PDJ_PULL_DOWN = 2'h3;

   // -----------------------------------------------------------------
   // Dejitter circuit indices
   // -----------------------------------------------------------------
   localparam int PDJ_DJ_ADC   = 0;
   localparam int PDJ_DJ_SPORT = 1;
   localparam int PDJ_DJ_CORE  = 2;
   localparam int PDJ_DJ_DAC   = 3;
   localparam int PDJ_DJ_NUM   = 4;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } pdj_req_t;

   typedef struct packed {
      logic adc_en;
      logic dmic_en;
      logic mem_en;
      logic sport_en;
      logic rec_route_en;
      logic play_route_en;
      logic clkgen_en;
      logic core_en;
      logic dac_en;
   } pdj_gate_t;

endpackage

/* File: src/pdj_dejitter.sv */
`timescale 1ns/1ps
module pdj_dejitter
   import pdj_pkg::*;
#(
   parameter int WIN_W = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   input  wire logic [WIN_W-1:0] window,
   input  wire logic             subsys_en,
   input  wire logic             frame_async,
   output logic                  sample_stb_ff,
   output logic                  stuck_ff
);

   initial begin
      if (WIN_W < 1 || WIN_W > 16) begin
         $error("pdj_dejitter: WIN_W out of range");
      end
   end

   // -----------------------------------------------------------------
   // Input synchroniser
   // -----------------------------------------------------------------
   logic             sync1_ff, sync2_ff, sync3_ff, lvl_ff;
   logic [WIN_W-1:0] cnt_ff;
   logic             pend_ff, en_prev_ff;
   logic             bypass, evt;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         sync3_ff <= 1'b0;
      end else begin
         sync1_ff <= frame_async;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end

   assign bypass = (window == '0);
   // Rising frame edge once the two late stages agree
   assign evt    = (sync2_ff == sync3_ff) && (sync3_ff != lvl_ff) && sync3_ff;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         lvl_ff <= 1'b0;
      end else if (sync2_ff == sync3_ff) begin
         lvl_ff <= sync3_ff;
      end
   end

   // -----------------------------------------------------------------
   // Window: doubles collapse, one late edge is held, not dropped
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_ff        <= '0;
         pend_ff       <= 1'b0;
         sample_stb_ff <= 1'b0;
      end else if (bypass) begin
         cnt_ff        <= '0;
         pend_ff       <= 1'b0;
         sample_stb_ff <= evt && subsys_en;
      end else if (cnt_ff != '0) begin
         cnt_ff        <= cnt_ff - 1'b1;
         pend_ff       <= pend_ff || evt;
         sample_stb_ff <= 1'b0;
      end else if (evt || pend_ff) begin
         cnt_ff        <= window;
         pend_ff       <= 1'b0;
         sample_stb_ff <= subsys_en && !stuck_ff;
      end else begin
         sample_stb_ff <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Stuck state after a subsystem off/on while active
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         en_prev_ff <= 1'b0;
         stuck_ff   <= 1'b0;
      end else begin
         en_prev_ff <= subsys_en;
         if (bypass) begin
            stuck_ff <= 1'b0;
         end else if (en_prev_ff && !subsys_en) begin
            stuck_ff <= 1'b1;
         end
      end
   end

endmodule

/* File: verification/pdj_monitor.sv */
`timescale 1ns/1ps
module pdj_monitor
   import pdj_pkg::*;
#(
   parameter int WIN_W = 8
) (
   input wire logic                  clk_sys,
   input wire logic                  sys_rst,
   input wire pdj_req_t              reg_req,
   input wire logic [7:0]            rd_data_ff,
   input wire logic                  rd_valid_ff,
   input wire logic                  mem_req,
   input wire logic                  mem_grant_ff,
   input wire logic                  mem_reject_ff,
   input wire logic [PDJ_DJ_NUM-1:0] frame_in,
   input wire logic [PDJ_DJ_NUM-1:0] sample_stb_ff,
   input wire logic [PDJ_DJ_NUM-1:0] dejit_stuck_ff,
   input wire logic [3:0]            pad_pull_up_ff,
   input wire logic [3:0]            pad_pull_down_ff,
   input wire logic [3:0]            pad_drive_hi_ff,
   input wire logic                  cko_drive_hi_ff,
   input wire logic                  cko_pull_up_ff,
   input wire logic                  cko_pull_down_ff,
   input wire logic [7:0]            dejit_window_ff,
   input wire pdj_gate_t             gate_ff
);
   // ------------------------------
   // Helpers
   // ------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   function automatic logic [3:0] code_is(input logic [7:0] w, input logic [1:0] c);
      return {w[7:6] == c, w[5:4] == c, w[3:2] == c, w[1:0] == c};
   endfunction

   // Field order follows the gate struct: adc, dmic, mem, sport, rec, play, clkgen, core, dac
   function automatic logic [8:0] gate_of(input logic [7:0] w);
      return {w[7] & w[6], w[7], w[6] & w[0], w[5] | w[4], w[3], w[2], w[1], w[0] & w[6], w[6]};
   endfunction

   function automatic logic mapped(input logic [15:0] a);
      return a inside {PDJ_OFF_COMM_PULLS, PDJ_OFF_COMM_DRIVE, PDJ_OFF_CLKOUT_PAD, PDJ_OFF_DEJIT_WIN,
                       PDJ_OFF_PWR_GATE0};
   endfunction

   sequence s_wr(logic [15:0] a);
      reg_req.wr && reg_req.addr == a;
   endsequence

   // Derived pad and gate outputs lag the register by one more edge
   sequence s_wr_seen(logic [15:0] a);
      s_wr(a) ##2 1'b1;
   endsequence

   // ------------------------------
   // Assertions
   // ------------------------------
   a_pull_up_map: assert property (s_wr_seen(PDJ_OFF_COMM_PULLS) |->
      pad_pull_up_ff == code_is($past(reg_req.wdata, 2), 2'h0)) else $error("pull-up decode wrong");
   a_pull_down_map: assert property (s_wr_seen(PDJ_OFF_COMM_PULLS) |->
      pad_pull_down_ff == code_is($past(reg_req.wdata, 2), 2'h3)) else $error("pull-down decode wrong");
   a_drive_map: assert property (s_wr_seen(PDJ_OFF_COMM_DRIVE) |->
      pad_drive_hi_ff == $past(reg_req.wdata[3:0], 2)) else $error("pad drive wrong");
   a_clkout_pad_map: assert property (s_wr_seen(PDJ_OFF_CLKOUT_PAD) |->
      {cko_drive_hi_ff, cko_pull_up_ff, cko_pull_down_ff} == ($past(reg_req.wdata[2:0], 2) ^ 3'h2))
      else $error("clock-out pad wrong");
   a_window_load: assert property (s_wr(PDJ_OFF_DEJIT_WIN) |=>
      dejit_window_ff == $past(reg_req.wdata)) else $error("window load wrong");
   a_gate_map: assert property (s_wr_seen(PDJ_OFF_PWR_GATE0) |->
      gate_ff == gate_of($past(reg_req.wdata, 2))) else $error("power gate wrong");
   a_stuck_clear: assert property ((dejit_window_ff == 8'h00) [*2] |->
      dejit_stuck_ff == '0) else $error("stuck not cleared");
   a_strobe_gap: assert property (sample_stb_ff[1] && dejit_window_ff > 8'h04 |=>
      (!sample_stb_ff[1]) [*4]) else $error("strobe inside window");
   a_odd_read_zero: assert property (reg_req.rd && !mapped(reg_req.addr) |=>
      rd_valid_ff && rd_data_ff == 8'h00) else $error("unmapped read wrong");
   a_mem_answer: assert property (mem_req |=>
      mem_grant_ff == gate_ff.mem_en && mem_reject_ff == !gate_ff.mem_en) else $error("memory answer wrong");
endmodule

bind pdj_top pdj_monitor #(.WIN_W(WIN_W)) i_pdj_monitor (
   .clk_sys, .sys_rst, .reg_req, .rd_data_ff, .rd_valid_ff, .mem_req, .mem_grant_ff, .mem_reject_ff,
   .frame_in, .sample_stb_ff, .dejit_stuck_ff, .pad_pull_up_ff, .pad_pull_down_ff, .pad_drive_hi_ff,
   .cko_drive_hi_ff, .cko_pull_up_ff, .cko_pull_down_ff, .dejit_window_ff, .gate_ff
);

/* File: verification/test_pdj_top.sv */
`timescale 1ns/1ps
module test_pdj_top;
   import pdj_pkg::*;
   logic                  clk_sys;
   logic                  sys_rst;
   pdj_req_t              reg_req;
   logic                  mem_req;
   logic [PDJ_DJ_NUM-1:0] frame_in;
   logic [7:0]            rd_data_ff, dejit_window_ff;
   logic                  rd_valid_ff, mem_grant_ff, mem_reject_ff;
   logic                  cko_drive_hi_ff, cko_pull_up_ff, cko_pull_down_ff;
   logic [PDJ_DJ_NUM-1:0] sample_stb_ff, dejit_stuck_ff;
   logic [3:0]            pad_pull_up_ff, pad_pull_down_ff, pad_drive_hi_ff;
   pdj_gate_t             gate_ff;
   int                    num_errors;
   int                    checks_done;

   // ------------------------------
   // Design under test
   // ------------------------------
   pdj_top #(.WIN_W(8)) i_pdj_top (
      .clk_sys, .sys_rst, .reg_req, .rd_data_ff, .rd_valid_ff, .mem_req, .mem_grant_ff, .mem_reject_ff,
      .frame_in, .sample_stb_ff, .dejit_stuck_ff, .pad_pull_up_ff, .pad_pull_down_ff, .pad_drive_hi_ff,
      .cko_drive_hi_ff, .cko_pull_up_ff, .cko_pull_down_ff, .dejit_window_ff, .gate_ff
   );

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // ------------------------------
   // Bus and check tasks
   // ------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      if (num_errors == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys);
      reg_req.wr <= 1'b0;
   endtask

   // Read data stands one cycle only, so it is sampled just after the answering edge
   task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_sys);
      reg_req.rd <= 1'b0;
      #1;
      check(16'(rd_valid_ff), 16'h0001);
      check(16'(rd_data_ff), 16'(exp));
   endtask

   task automatic settle;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask

   function automatic logic [8:0] gate_of(input logic [7:0] w);
      return {w[7] & w[6], w[7], w[6] & w[0], w[5] | w[4], w[3], w[2], w[1], w[0] & w[6], w[6]};
   endfunction

   // Frame edges two cycles high, two low; strobes counted over a fixed span
   task automatic burst(input int idx, input int cnt, output int n);
      int hits;
      hits = 0;
      fork
         for (int k = 0; k < cnt; k++) begin
            @(posedge clk_sys) frame_in[idx] <= 1'b1;
            repeat (2) @(posedge clk_sys);
            frame_in[idx] <= 1'b0;
            @(posedge clk_sys);
         end
         repeat (60) begin
            @(posedge clk_sys);
            #1;
            if (sample_stb_ff[idx] === 1'b1) hits++;
         end
      join
      n = hits;
   endtask

   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_reset_values;
      rd_reg(PDJ_OFF_COMM_PULLS, 8'hCF);
      rd_reg(PDJ_OFF_COMM_DRIVE, 8'h00);
      rd_reg(PDJ_OFF_CLKOUT_PAD, 8'h01);
      rd_reg(PDJ_OFF_DEJIT_WIN, 8'h05);
      rd_reg(PDJ_OFF_PWR_GATE0, 8'h00);
      check(16'(pad_pull_up_ff), 16'h0004);
      check(16'(pad_pull_down_ff), 16'h000B);
      check(16'({cko_drive_hi_ff, cko_pull_up_ff, cko_pull_down_ff}), 16'h0003);
      check(16'(gate_ff), 16'h0000);
   endtask

   task automatic t_pull_codes;
      logic [1:0] c;
      for (int k = 0; k < 4; k++) begin
         c = 2'(k);
         wr_reg(PDJ_OFF_COMM_PULLS, {c, c, c, c});
         settle();
         check(16'(pad_pull_up_ff), (c == 2'h0) ? 16'h000F : 16'h0000);
         check(16'(pad_pull_down_ff), (c == 2'h3) ? 16'h000F : 16'h0000);
         rd_reg(PDJ_OFF_COMM_PULLS, {c, c, c, c});
      end
      // Mixed codes pin down the field order
      wr_reg(PDJ_OFF_COMM_PULLS, 8'h1B);
      settle();
      check(16'({pad_pull_up_ff, pad_pull_down_ff}), 16'h0081);
   endtask

   task automatic pad_case(input logic [7:0] dw, input logic [7:0] cw, input logic [6:0] exp);
      wr_reg(PDJ_OFF_COMM_DRIVE, dw);
      wr_reg(PDJ_OFF_CLKOUT_PAD, cw);
      settle();
      check(16'({pad_drive_hi_ff, cko_drive_hi_ff, cko_pull_up_ff, cko_pull_down_ff}), 16'(exp));
      rd_reg(PDJ_OFF_COMM_DRIVE, dw & 8'h0F);
      rd_reg(PDJ_OFF_CLKOUT_PAD, cw & 8'h07);
   endtask

   task automatic t_pad_bits;
      pad_case(8'hF5, 8'hFC, 7'h2E);
      pad_case(8'hFA, 8'hFB, 7'h51);
      wr_reg(16'h4033, 8'hFF);
      rd_reg(16'h4033, 8'h00);
      rd_reg(PDJ_OFF_DEJIT_WIN, 8'h05);
   endtask

   task automatic t_power_gate;
      logic [7:0] vals [12] = '{8'h80, 8'hC0, 8'h20, 8'h10, 8'h30, 8'h08, 8'h04, 8'h02, 8'h41, 8'h01,
                                8'h40, 8'h00};
      for (int k = 0; k < 12; k++) begin
         wr_reg(PDJ_OFF_PWR_GATE0, vals[k]);
         settle();
         check(16'(gate_ff), 16'(gate_of(vals[k])));
         @(posedge clk_sys) mem_req <= 1'b1;
         @(posedge clk_sys) mem_req <= 1'b0;
         #1;
         check(16'({mem_grant_ff, mem_reject_ff}), (vals[k][6] & vals[k][0]) ? 16'h0002 : 16'h0001);
      end
   endtask

   task automatic t_dejitter;
      int n;
      // Gating above never enabled a circuit (clkgen bit only set alone), so none is stuck; zero window clears stuck first
      wr_reg(PDJ_OFF_DEJIT_WIN, 8'h00);
      wr_reg(PDJ_OFF_PWR_GATE0, 8'hFF);
      wr_reg(PDJ_OFF_DEJIT_WIN, 8'h14);
      settle();
      check(16'(dejit_stuck_ff), 16'h0000);
      burst(1, 3, n);
      check(16'(n), 16'h0002);
      wr_reg(PDJ_OFF_DEJIT_WIN, 8'h00);
      settle();
      burst(1, 3, n);
      check(16'(n), 16'h0003);
      wr_reg(PDJ_OFF_DEJIT_WIN, 8'h05);
      wr_reg(PDJ_OFF_PWR_GATE0, 8'h00);
      wr_reg(PDJ_OFF_PWR_GATE0, 8'hFF);
      settle();
      check(16'(dejit_stuck_ff[1]), 16'h0001);
      burst(1, 1, n);
      check(16'(n), 16'h0000);
      wr_reg(PDJ_OFF_DEJIT_WIN, 8'h00);
      wr_reg(PDJ_OFF_DEJIT_WIN, 8'h05);
      settle();
      check(16'(dejit_stuck_ff), 16'h0000);
      burst(1, 1, n);
      check(16'(n), 16'h0001);
      for (int i = 0; i < PDJ_DJ_NUM; i += 2) begin
         burst(i, 1, n);
         check(16'(n), 16'h0001);
      end
      burst(3, 1, n);
      check(16'(n), 16'h0001);
   endtask

   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      num_errors = 0;
      checks_done = 0;
      sys_rst = 1'b1;
      reg_req = '0;
      mem_req = 1'b0;
      frame_in = '0;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_reset_values();
      t_pull_codes();
      t_pad_bits();
      t_power_gate();
      t_dejitter();
      wrap_up();
   end

   // Whole run is well under a thousand cycles
   initial begin
      #(25 * 4000);
      num_errors++;
      wrap_up();
   end
endmodule
